/* File: baala_map.vh */
// register map, field positions, reset values and counts of the byte alu
`ifndef BAALA_MAP_VH
`define BAALA_MAP_VH

// register byte offsets
`define BAALA_OFS_OPCODE 8'h00
`define BAALA_OFS_SRC 8'h04
`define BAALA_OFS_DST 8'h08
`define BAALA_OFS_STATUS 8'h0C
`define BAALA_OFS_INFO 8'h10

// status register fields
`define BAALA_ST_CARRY 0
`define BAALA_ST_SIGN 1
`define BAALA_ST_ZERO 2
`define BAALA_ST_OVFL 3
`define BAALA_ST_PEND 4
`define BAALA_ST_BAD 5

// info register fields
`define BAALA_INFO_INSN_LSB 0
`define BAALA_INFO_OPC_LSB 8

// instruction set facts
`define BAALA_INSN_COUNT 8'h49
`define BAALA_OPCODE_COUNT 8'hF5
`define BAALA_PREFIX_OPCODE 8'hF4

// low nibble of each supported operation
`define BAALA_NIB_AND 4'h3
`define BAALA_NIB_ADC 4'h9
`define BAALA_NIB_ADD 4'hA
// highest addressing-form nibble of the three operations
`define BAALA_FORM_MAX 4'hA

// reset values
`define BAALA_RST_BYTE 8'h00
`define BAALA_RST_FLAG 1'b0

// axi responses
`define BAALA_RESP_OKAY 2'b00
`define BAALA_RESP_DECERR 2'b11

`endif

/* File: baala_monitor.sv */
// bus and info checks of the byte alu
`timescale 1ns/1ps
`default_nettype none
module baala_monitor #(
    parameter AXI_ADDR_W = 8
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    sequence ar_take;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence wr_take;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    a_info_read:
    assert property (ar_take ##0 S_AXI_ARADDR == 'h10 |=>
        S_AXI_RDATA == 32'h0000F549) else $error("info word wrong");
    a_unmapped_read:
    assert property (ar_take ##0 S_AXI_ARADDR == 'h14 |=>
        S_AXI_RRESP == 2'b11 && S_AXI_RDATA == 0) else $error("bad rd");
    a_read_answer:
    assert property (ar_take |=> S_AXI_RVALID) else $error("no rvalid");
    a_write_answer:
    assert property (wr_take ##0 !S_AXI_BVALID |=>
        !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("no bvalid");
    a_b_hold:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("b lost");
    a_r_hold:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID &&
        $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP)) else $error("r lost");
    a_r_drop:
    assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("r stuck");
    a_ar_gate:
    assert property (S_AXI_ARREADY == !S_AXI_RVALID) else $error("arready");
    a_aw_held:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("awready");
endmodule // baala_monitor
bind baala_top baala_monitor #(.AXI_ADDR_W(AXI_ADDR_W)) mon_u (
    .SYS_CLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);
`default_nettype wire

/* File: baala_top.v */
// byte add, add-with-carry and and datapath behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "baala_map.vh"

module baala_top #(
    parameter AXI_ADDR_W = 8
) (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire [AXI_ADDR_W-1:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);

////////////////////////////////////////////////////////////////////////////////
// operation codes

localparam OP_NONE = 2'd0;
localparam OP_ADD = 2'd1;
localparam OP_ADC = 2'd2;
localparam OP_AND = 2'd3;

reg [7:0] source_operand_reg;
reg [7:0] dst_reg;
reg [7:0] opcode_reg;
reg carry_reg;
reg sign_reg;
reg zero_reg;
reg ovfl_reg;
reg pend_reg;
reg bad_reg;

reg aw_hold_reg;
reg w_hold_reg;
reg [AXI_ADDR_W-1:0] aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;

////////////////////////////////////////////////////////////////////////////////
// decode: operation follows from opcode value; exec_op forces none while pend_reg is set

function [1:0] decode_op;
    input [7:0] opc;
    begin
        decode_op = OP_NONE;
        if (opc[7:4] != 4'h0 && opc[7:4] <= `BAALA_FORM_MAX) begin
            case (opc[3:0])
                `BAALA_NIB_ADD: decode_op = OP_ADD;
                `BAALA_NIB_ADC: decode_op = OP_ADC;
                `BAALA_NIB_AND: decode_op = OP_AND;
                default: decode_op = OP_NONE;
            endcase
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// write channel

wire wr_fire = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;
wire [7:0] wr_ofs = aw_addr_reg[7:0];
wire wr_lane0 = w_strb_reg[0];
wire [7:0] wr_byte = w_data_reg[7:0];

assign S_AXI_AWREADY = !aw_hold_reg;
assign S_AXI_WREADY = !w_hold_reg;

wire wr_mapped = (wr_ofs == `BAALA_OFS_OPCODE) ||
                 (wr_ofs == `BAALA_OFS_SRC) ||
                 (wr_ofs == `BAALA_OFS_DST) ||
                 (wr_ofs == `BAALA_OFS_STATUS) ||
                 (wr_ofs == `BAALA_OFS_INFO);

always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        aw_addr_reg <= {AXI_ADDR_W{1'b0}};
        w_data_reg <= 32'h00000000;
        w_strb_reg <= 4'h0;
        S_AXI_BVALID <= 1'b0;
        S_AXI_BRESP <= `BAALA_RESP_OKAY;
    end else begin
        if (S_AXI_AWVALID && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
        end
        if (wr_fire) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_mapped ? `BAALA_RESP_OKAY : `BAALA_RESP_DECERR;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// datapath

wire exec_wr = wr_fire && wr_lane0 && (wr_ofs == `BAALA_OFS_OPCODE);
wire [1:0] exec_op = pend_reg ? OP_NONE : decode_op(wr_byte);
wire carry_in = (exec_op == OP_ADC) ? carry_reg : 1'b0;
// zero source with carry in gives conditional increment
wire [8:0] sum9 = {1'b0, source_operand_reg} + {1'b0, dst_reg} +
                  {8'h00, carry_in};

reg [7:0] result;
reg res_carry;
reg res_ovfl;

always @* begin
    result = dst_reg;
    res_carry = carry_reg;
    res_ovfl = ovfl_reg;
    case (exec_op)
        OP_ADD, OP_ADC: begin
            result = sum9[7:0];
            res_carry = sum9[8];
            res_ovfl = (sum9[8] ^ sum9[7]) &
                ~(source_operand_reg[7] ^ dst_reg[7]);
        end
        OP_AND: begin
            result = source_operand_reg & dst_reg;
            res_carry = 1'b0;
            res_ovfl = 1'b0;
        end
        default: begin
            result = dst_reg;
            res_carry = carry_reg;
            res_ovfl = ovfl_reg;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// registers and flags

wire st_wr = wr_fire && wr_lane0 && (wr_ofs == `BAALA_OFS_STATUS);

always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        source_operand_reg <= `BAALA_RST_BYTE;
        dst_reg <= `BAALA_RST_BYTE;
        opcode_reg <= `BAALA_RST_BYTE;
        carry_reg <= `BAALA_RST_FLAG;
        sign_reg <= `BAALA_RST_FLAG;
        zero_reg <= `BAALA_RST_FLAG;
        ovfl_reg <= `BAALA_RST_FLAG;
        pend_reg <= `BAALA_RST_FLAG;
        bad_reg <= `BAALA_RST_FLAG;
    end else begin
        if (wr_fire && wr_lane0 && wr_ofs == `BAALA_OFS_SRC) begin
            source_operand_reg <= wr_byte;
        end
        if (wr_fire && wr_lane0 && wr_ofs == `BAALA_OFS_DST) begin
            dst_reg <= wr_byte;
        end
        if (st_wr) begin
            carry_reg <= wr_byte[`BAALA_ST_CARRY];
            sign_reg <= wr_byte[`BAALA_ST_SIGN];
            zero_reg <= wr_byte[`BAALA_ST_ZERO];
            ovfl_reg <= wr_byte[`BAALA_ST_OVFL];
            if (wr_byte[`BAALA_ST_BAD]) begin
                bad_reg <= 1'b0;
            end
        end
        if (exec_wr) begin
            opcode_reg <= wr_byte;
            if (pend_reg) begin
                // second byte ends decode; no op here lives in that page
                pend_reg <= 1'b0;
                bad_reg <= 1'b1;
            end else if (wr_byte == `BAALA_PREFIX_OPCODE) begin
                pend_reg <= 1'b1;
            end else if (exec_op == OP_NONE) begin
                bad_reg <= 1'b1;
            end else begin
                dst_reg <= result;
                carry_reg <= res_carry;
                ovfl_reg <= res_ovfl;
                zero_reg <= (result == 8'h00);
                sign_reg <= result[7];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read channel

wire [7:0] rd_ofs = S_AXI_ARADDR[7:0];
assign S_AXI_ARREADY = !S_AXI_RVALID;

reg [31:0] rd_word;
reg rd_hit;

always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (rd_ofs)
        `BAALA_OFS_OPCODE: rd_word[7:0] = opcode_reg;
        `BAALA_OFS_SRC: rd_word[7:0] = source_operand_reg;
        `BAALA_OFS_DST: rd_word[7:0] = dst_reg;
        `BAALA_OFS_STATUS: begin
            rd_word[`BAALA_ST_CARRY] = carry_reg;
            rd_word[`BAALA_ST_SIGN] = sign_reg;
            rd_word[`BAALA_ST_ZERO] = zero_reg;
            rd_word[`BAALA_ST_OVFL] = ovfl_reg;
            rd_word[`BAALA_ST_PEND] = pend_reg;
            rd_word[`BAALA_ST_BAD] = bad_reg;
        end
        `BAALA_OFS_INFO: begin
            rd_word[`BAALA_INFO_INSN_LSB+7:`BAALA_INFO_INSN_LSB] =
                `BAALA_INSN_COUNT;
            rd_word[`BAALA_INFO_OPC_LSB+7:`BAALA_INFO_OPC_LSB] =
                `BAALA_OPCODE_COUNT;
        end
        default: rd_hit = 1'b0;
    endcase
end

always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_RDATA <= 32'h00000000;
        S_AXI_RRESP <= `BAALA_RESP_OKAY;
    end else begin
        if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_word;
            S_AXI_RRESP <= rd_hit ? `BAALA_RESP_OKAY : `BAALA_RESP_DECERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
end

endmodule // baala_top

`default_nettype wire

/* File: tb_baala_top.sv */
// random and corner bench of the byte alu
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_baala_top;
logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
logic [7:0] awaddr = 0, araddr = 0, op, s, d;
logic [31:0] wdata = 0, lfsr = 32'h549C;
logic [3:0] wstrb = 4'hF, st;
logic [11:0] e;
wire awrdy, wrdy, bv, arrdy, rv;
wire [1:0] br, rr;
wire [31:0] rdo;
int fails = 0, n_checks = 0, k;
logic [31:0] cor [5] = '{32'h2AFF0101, 32'h1A7F0100, 32'h7900FF01,
    32'h19000500, 32'h99808001};
baala_top #(.AXI_ADDR_W(8)) dut_u (.SYS_CLK(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdo), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));
always #5 clk = ~clk;
////////////////////////////////////////////////////////////
task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
task automatic hang;
    fails++;
    tally_and_finish;
endtask
task automatic wr(input [7:0] a, input [31:0] v, input [1:0] er);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    for (i = 0; i < 50; i++) begin
        @(posedge clk);
        if (awrdy) awv <= 0;
        if (wrdy) wv <= 0;
        if (bv) break;
    end
    bready <= 0;
    if (i == 50) hang();
    `CHK(br, er)
endtask
task automatic rd(input [7:0] a, input [31:0] v, input [1:0] er);
    int i;
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    for (i = 0; i < 50; i++) begin
        @(posedge clk);
        if (arrdy) arv <= 0;
        if (rv) break;
    end
    rready <= 0;
    if (i == 50) hang();
    `CHK(rdo, v)
    `CHK(rr, er)
endtask
function automatic [31:0] nxt(input [31:0] x);
    nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
function automatic [11:0] alu(input [7:0] o, a, b, input c);
    logic [8:0] r;
    logic v;
    if (o[3:0] == 4'h3) r = {1'b0, a & b};
    else r = a + b + (c & (o[3:0] == 4'h9));
    v = (r[8] ^ r[7]) & ~(a[7] ^ b[7]) & (o[3:0] != 4'h3);
    alu = {r[7:0], v, r[7:0] == 8'h00, r[7], r[8]};
endfunction
////////////////////////////////////////////////////////////
initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    for (k = 0; k < 4; k++) rd(8'(k * 4), 0, 2'b00);
    rd(8'h10, 32'hF549, 2'b00);
    wr(8'h14, 1, 2'b11);
    rd(8'h14, 0, 2'b11);
    for (k = 0; k < 60; k++) begin
        lfsr = nxt(lfsr);
        {op, s, d} = cor[k % 5][31:8];
        if (!k[0]) st = (k < 5) ? cor[k][3:0] : lfsr[27:24];
        if (k >= 5) begin
            op = {lfsr[3:0] % 4'hA + 4'h1, lfsr[5] ? 4'hA :
                (lfsr[4] ? 4'h9 : 4'h3)};
            s = lfsr[15:8];
            d = lfsr[23:16];
        end
        wr(8'h04, s, 2'b00);
        wr(8'h08, d, 2'b00);
        if (!k[0]) wr(8'h0C, st, 2'b00);
        wr(8'h00, op, 2'b00);
        e = alu(op, s, d, st[0]);
        st = e[3:0];
        rd(8'h08, e[11:4], 2'b00);
        rd(8'h0C, st, 2'b00);
    end
    wr(8'h00, 8'hF4, 2'b00);
    rd(8'h0C, st | 8'h10, 2'b00);
    wr(8'h00, 8'hEC, 2'b00);
    rd(8'h0C, st | 8'h20, 2'b00);
    rd(8'h08, e[11:4], 2'b00);
    wstrb <= 4'h0;
    wr(8'h08, 8'h55, 2'b00);
    wstrb <= 4'hF;
    rd(8'h08, e[11:4], 2'b00);
    wr(8'h0C, 8'h20, 2'b00);
    rd(8'h0C, 0, 2'b00);
    tally_and_finish;
end
endmodule // tb_baala_top
`default_nettype wire
